/* File: ep0sr_core.sv */
// Purpose: endpoint-zero standard request handler: configuration,
//          alternate settings, device address and frame timing.
// Assumes: serial engine signals share clk and arrive already decoded;
//          firmware reaches the registers over AXI4-Lite.
// Notes:   usb_reset and detach both count as re-enumeration.
module ep0sr_core #(
  parameter int NUM_IF = 4,
  parameter int SOF_CYCLES = ep0sr_pkg::SOF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [ep0sr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ep0sr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial engine side
  input wire logic setup_valid,
  input wire logic [63:0] setup_bytes,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  input wire logic tok_valid,
  input wire logic [6:0] tok_addr,
  input wire logic status_tok,
  input wire logic in_done,
  input wire logic usb_reset,
  input wire logic detach,
  output logic [6:0] function_address,
  output logic addr_match,
  output logic status_ack,
  output logic status_nak,
  output logic [31:0] control_in_buffer,
  output logic [7:0] control_in_byte_count,
  output logic in_armed,
  output logic sof_event,
  output logic [10:0] frame_count,
  output logic [15:0] ep_mask,
  output logic ep_toggle_rst,
  output logic ep_busy_clr,
  output logic ep_out_rearm,
  output logic sync_valid,
  output logic [7:0] sync_endpoint_code
);
  localparam int IW = (NUM_IF > 1) ? $clog2(NUM_IF) : 1;

  // control transfer progress
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FW,
    ST_ADDR
  } ep0sr_st_t;

  typedef struct packed {
    ep0sr_st_t st;
    logic [63:0] setup;
    logic nak;
    logic [6:0] fa;
    logic [6:0] fa_pend;
    logic [10:0] frame;
    logic [7:0] cfg;
    logic [NUM_IF-1:0][7:0] alt;
    logic [31:0] ibuf;
    logic [7:0] ibc;
    logic armed;
    logic [15:0] mask;
    logic tog;
    logic bclr;
    logic orarm;
    logic sof;
    logic match;
    logic ack;
    logic nakp;
    logic sync_v;
    logic [7:0] sync_ep;
  } ep0sr_cs_t;

  ep0sr_cs_t c_q, c_d;

  ep0sr_rb_if rb();
  ep0sr_tmr_if tm();

  ep0sr_axil u_axil (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb.slave)
  );

  ep0sr_sof_timer #(
    .PERIOD(SOF_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tm(tm.timer)
  );

  // setup byte fields
  function automatic logic [7:0] sbyte(logic [63:0] s, int n);
    return s[n*8 +: 8];
  endfunction

  // address decode shared by the read and write paths
  function automatic logic mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ep0sr_pkg::OFS_SYNC);
  endfunction

  // interface index, out-of-range interfaces read back zero
  function automatic logic if_ok(logic [7:0] n);
    return int'(n) < NUM_IF;
  endfunction

  // request type and code of the latched setup packet
  logic [7:0] rq_type, rq_code, rq_if;
  assign rq_type = sbyte(c_q.setup, 0);
  assign rq_code = sbyte(c_q.setup, 1);
  assign rq_if = sbyte(c_q.setup, 4);

  // timer sees every frame so synthesised frames re-time themselves
  assign tm.seen = sof_valid || tm.miss;
  assign tm.clear = usb_reset || detach;

  assign function_address = c_q.fa;
  assign addr_match = c_q.match;
  assign status_ack = c_q.ack;
  assign status_nak = c_q.nakp;
  assign control_in_buffer = c_q.ibuf;
  assign control_in_byte_count = c_q.ibc;
  assign in_armed = c_q.armed;
  assign sof_event = c_q.sof;
  assign frame_count = c_q.frame;
  assign ep_mask = c_q.mask;
  assign ep_toggle_rst = c_q.tog;
  assign ep_busy_clr = c_q.bclr;
  assign ep_out_rearm = c_q.orarm;
  assign sync_valid = c_q.sync_v;
  assign sync_endpoint_code = c_q.sync_ep;

  // register read mux, answered in the cycle of the address
  always_comb begin
    rb.rdata = 32'h0000_0000;
    rb.rd_ok = mapped(rb.rd_addr);
    rb.wr_ok = mapped(rb.wr_addr);
    case (rb.rd_addr)
      ep0sr_pkg::OFS_SETUP_LO: rb.rdata = c_q.setup[31:0];
      ep0sr_pkg::OFS_SETUP_HI: rb.rdata = c_q.setup[63:32];
      ep0sr_pkg::OFS_CTRL: begin
        rb.rdata[ep0sr_pkg::CTRL_NAK_BIT] = c_q.nak;
        rb.rdata[ep0sr_pkg::CTRL_ARMED_BIT] = c_q.armed;
      end
      ep0sr_pkg::OFS_IN_BC: rb.rdata[7:0] = c_q.ibc;
      ep0sr_pkg::OFS_IN_BUF: rb.rdata = c_q.ibuf;
      ep0sr_pkg::OFS_FN_ADDR: rb.rdata[6:0] = c_q.fa;
      ep0sr_pkg::OFS_FRAME_LO: rb.rdata[7:0] = c_q.frame[7:0];
      ep0sr_pkg::OFS_FRAME_HI: rb.rdata[2:0] = c_q.frame[10:8];
      ep0sr_pkg::OFS_CONFIG: rb.rdata[7:0] = c_q.cfg;
      ep0sr_pkg::OFS_ALT: begin
        // alternate setting of the interface named in setup byte 4
        if (if_ok(rq_if)) begin
          rb.rdata[7:0] = c_q.alt[rq_if[IW-1:0]];
        end
      end
      ep0sr_pkg::OFS_SYNC: begin
        rb.rdata[7:0] = c_q.sync_ep;
        rb.rdata[8] = c_q.sync_v;
      end
      default: rb.rdata = 32'h0000_0000;
    endcase
  end

  // next state of the whole handler
  always_comb begin
    logic [31:0] wv;
    logic [7:0] wif;
    wv = 32'h0000_0000;
    wif = 8'h00;
    c_d = c_q;
    c_d.ack = 1'b0;
    c_d.nakp = 1'b0;
    c_d.sof = 1'b0;
    c_d.tog = 1'b0;
    c_d.bclr = 1'b0;
    c_d.orarm = 1'b0;
    c_d.match = 1'b0;

    // firmware writes
    if (rb.wr_en) begin
      case (rb.wr_addr)
        ep0sr_pkg::OFS_CTRL: begin
          // write one clears; a new setup below still wins
          if (rb.wstrb[0] && rb.wdata[ep0sr_pkg::CTRL_NAK_BIT]) begin
            c_d.nak = 1'b0;
          end
        end
        ep0sr_pkg::OFS_IN_BC: begin
          if (rb.wstrb[0]) begin
            c_d.ibc = rb.wdata[7:0];
            c_d.armed = 1'b1;
          end
        end
        ep0sr_pkg::OFS_IN_BUF: begin
          c_d.ibuf = ep0sr_pkg::wmerge(c_q.ibuf, rb.wdata, rb.wstrb);
        end
        ep0sr_pkg::OFS_CONFIG: begin
          if (rb.wstrb[0]) begin
            c_d.cfg = rb.wdata[7:0];
          end
        end
        ep0sr_pkg::OFS_ALT: begin
          wv = ep0sr_pkg::wmerge(32'h0000_0000, rb.wdata, rb.wstrb);
          wif = wv[15:8];
          if (rb.wstrb[0] && if_ok(wif)) begin
            c_d.alt[wif[IW-1:0]] = wv[7:0];
          end
        end
        ep0sr_pkg::OFS_EP_CMD: begin
          // one-cycle strobes towards the endpoints in the mask
          wv = ep0sr_pkg::wmerge(32'h0000_0000, rb.wdata, rb.wstrb);
          c_d.mask = wv[15:0];
          c_d.tog = wv[ep0sr_pkg::EPC_TOGGLE_BIT];
          c_d.bclr = wv[ep0sr_pkg::EPC_BUSY_BIT];
          c_d.orarm = wv[ep0sr_pkg::EPC_REARM_BIT];
        end
        // the function address ignores writes; the bus still says OKAY
        default: c_d.nak = c_d.nak;
      endcase
    end

    // the serial engine finished sending the IN data
    if (in_done) begin
      c_d.armed = 1'b0;
    end

    // status stage: NAK while firmware still owns the request
    if (status_tok) begin
      if (c_q.st == ST_FW && c_q.nak) begin
        c_d.nakp = 1'b1;
      end else begin
        c_d.ack = 1'b1;
        if (c_q.st == ST_ADDR) begin
          c_d.fa = c_q.fa_pend;
        end
        c_d.st = ST_IDLE;
      end
    end

    // a new setup packet restarts the control transfer
    if (setup_valid) begin
      c_d.setup = setup_bytes;
      c_d.sync_v = 1'b0;
      if (sbyte(setup_bytes, 0) == ep0sr_pkg::TYPE_OUT_DEV &&
          sbyte(setup_bytes, 1) == ep0sr_pkg::REQ_SET_ADDR) begin
        // handled entirely in the core, no firmware turn
        c_d.st = ST_ADDR;
        c_d.fa_pend = setup_bytes[22:16];
        c_d.nak = 1'b0;
      end else begin
        c_d.st = ST_FW;
        c_d.nak = 1'b1;
      end
      if (sbyte(setup_bytes, 0) == ep0sr_pkg::TYPE_IN_EP &&
          sbyte(setup_bytes, 1) == ep0sr_pkg::REQ_SYNC) begin
        c_d.sync_ep = sbyte(setup_bytes, 4);
        c_d.sync_v = ep0sr_pkg::is_iso_ep(sbyte(setup_bytes, 4));
      end
    end

    // token address filter: zero until assigned, then only that one
    if (tok_valid) begin
      c_d.match = (tok_addr == c_q.fa);
    end

    // frames: packet number wins, a missed packet steps by one
    if (sof_valid) begin
      c_d.frame = sof_frame;
      c_d.sof = 1'b1;
    end else if (tm.miss) begin
      c_d.frame = c_q.frame + 11'h001;
      c_d.sof = 1'b1;
    end

    // bus reset or detach brings the device back as new
    if (usb_reset || detach) begin
      c_d.fa = ep0sr_pkg::RST_FN_ADDR;
      c_d.st = ST_IDLE;
      c_d.nak = 1'b0;
      c_d.cfg = ep0sr_pkg::RST_CONFIG;
      c_d.alt = '0;
      c_d.armed = 1'b0;
      c_d.match = 1'b0;
    end

    // guard against an illegal encoding of the progress field
    case (c_d.st)
      ST_IDLE, ST_FW, ST_ADDR: c_d.st = c_d.st;
      default: c_d.st = ST_IDLE;
    endcase
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= '0;
      c_q.st <= ST_IDLE;
      c_q.fa <= ep0sr_pkg::RST_FN_ADDR;
      c_q.frame <= ep0sr_pkg::RST_FRAME;
      c_q.cfg <= ep0sr_pkg::RST_CONFIG;
    end else if (ce) begin
      c_q <= c_d;
    end
  end
endmodule

/* File: ep0sr_pkg.sv */
// Purpose: constants, register map and helpers of the endpoint-zero
//          standard request handler.
// Assumes: 100 MHz clock, 32-bit AXI4-Lite register bus, 8-bit address.
// Notes:   every offset is a byte address of one aligned 32-bit word.
//
// Overview of operation
// - Set_Configuration 0x00/0x09 stores configuration from byte 2
// - writing one to handshake bit clears it
// - Get_Configuration 0x80/0x08 returns configuration, count one
// - Set_Interface 0x00/0x0B: alternate byte 2, interface byte 4
// - Set_Interface resets data toggles of interface endpoints
// - clear IN busy, re-arm OUT endpoints, then clear handshake
// - Get_Interface 0x81/0x0A returns stored alternate setting
// - answer address zero until Set_Address assigns one
// - core captures Set_Address, then matches only that address
// - address holds until detach, bus reset or power down
// - function address readable, firmware writes ignored
// - re-enumeration clears function address to zero
// - Sync_Frame 0x82/0x0C, endpoint 0x08-0x0F or 0x88-0x8F
// - firmware loads two-byte future frame into IN buffer
// - frame count readable as separate low and high
// - missing start-of-frame still raises event from timer
// - one start-of-frame event serves all isochronous endpoints
package ep0sr_pkg;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] OFS_SETUP_LO = 8'h00;
  localparam logic [7:0] OFS_SETUP_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_IN_BC = 8'h0C;
  localparam logic [7:0] OFS_IN_BUF = 8'h10;
  localparam logic [7:0] OFS_FN_ADDR = 8'h14;
  localparam logic [7:0] OFS_FRAME_LO = 8'h18;
  localparam logic [7:0] OFS_FRAME_HI = 8'h1C;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  localparam logic [7:0] OFS_ALT = 8'h24;
  localparam logic [7:0] OFS_EP_CMD = 8'h28;
  localparam logic [7:0] OFS_SYNC = 8'h2C;
  // field positions
  localparam int CTRL_NAK_BIT = 0;
  localparam int CTRL_ARMED_BIT = 1;
  localparam int EPC_TOGGLE_BIT = 16;
  localparam int EPC_BUSY_BIT = 17;
  localparam int EPC_REARM_BIT = 18;
  // request codes
  localparam logic [7:0] TYPE_OUT_DEV = 8'h00;
  localparam logic [7:0] TYPE_IN_DEV = 8'h80;
  localparam logic [7:0] TYPE_IN_IF = 8'h81;
  localparam logic [7:0] TYPE_IN_EP = 8'h82;
  localparam logic [7:0] REQ_SET_ADDR = 8'h05;
  localparam logic [7:0] REQ_GET_CFG = 8'h08;
  localparam logic [7:0] REQ_SET_CFG = 8'h09;
  localparam logic [7:0] REQ_GET_IF = 8'h0A;
  localparam logic [7:0] REQ_SET_IF = 8'h0B;
  localparam logic [7:0] REQ_SYNC = 8'h0C;
  // reset values
  localparam logic [6:0] RST_FN_ADDR = 7'h00;
  localparam logic [10:0] RST_FRAME = 11'h000;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // frame timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOF_PERIOD_NS = 1000000;
  localparam int SOF_CYC = SOF_PERIOD_NS / CLK_PERIOD_NS;

  // byte-enable merge of a register write
  function automatic logic [31:0] wmerge(logic [31:0] old,
                                         logic [31:0] nw,
                                         logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // isochronous endpoint code: OUT 0x08-0x0F or IN 0x88-0x8F
  function automatic logic is_iso_ep(logic [7:0] code);
    return (code[6:4] == 3'h0) && code[3];
  endfunction
endpackage

/* File: ep0sr_if.sv */
// Purpose: carriers between the handler core and its helpers.
// Assumes: one clock domain.
// Notes:   rdata and rd_ok answer rd_addr in the same cycle.
interface ep0sr_rb_if;
  logic wr_en;
  logic [ep0sr_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_ok;
  logic rd_en;
  logic [ep0sr_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] rdata;
  logic rd_ok;
  modport slave (output wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr,
                 input wr_ok, rdata, rd_ok);
  modport core (input wr_en, wr_addr, wdata, wstrb, rd_en, rd_addr,
                output wr_ok, rdata, rd_ok);
endinterface

interface ep0sr_tmr_if;
  logic seen;
  logic clear;
  logic miss;
  modport timer (input seen, clear, output miss);
  modport core (output seen, clear, input miss);
endinterface

/* File: ep0sr_axil.sv */
// Purpose: AXI4-Lite slave front end for the handler registers.
// Assumes: address and data of a write may arrive in either order.
// Notes:   one write and one read in flight; unmapped answers SLVERR.
module ep0sr_axil (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ep0sr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ep0sr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  ep0sr_rb_if.slave rb
);
  typedef struct packed {
    logic aw_got, w_got, awready, wready, arready, bvalid, rvalid;
    logic [ep0sr_pkg::ADDR_W-1:0] addr;
    logic [31:0] data, rdata;
    logic [3:0] strb;
    logic [1:0] bresp, rresp;
  } ep0sr_axs_t;
  ep0sr_axs_t s_q, s_d;

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign rb.wr_addr = s_q.addr;
  assign rb.wdata = s_q.data;
  assign rb.wstrb = s_q.strb;
  assign rb.rd_addr = araddr;

  // channel capture, write issue once both halves are held
  always_comb begin
    s_d = s_q;
    rb.wr_en = 1'b0;
    rb.rd_en = 1'b0;
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.data = wdata;
      s_d.strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      rb.wr_en = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rb.wr_ok ? ep0sr_pkg::RESP_OKAY : ep0sr_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      rb.rd_en = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rdata = rb.rdata;
      s_d.rresp = rb.rd_ok ? ep0sr_pkg::RESP_OKAY : ep0sr_pkg::RESP_SLVERR;
    end
    // ready drops while a half is held so payloads are never overwritten
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

/* File: ep0sr_sof_timer.sv */
// Purpose: frame timer that stands in for a lost start-of-frame packet.
// Assumes: seen pulses on every start-of-frame, real or synthesised.
// Notes:   stays idle until the first real packet after a clear.
module ep0sr_sof_timer #(
  parameter int PERIOD = ep0sr_pkg::SOF_CYC,
  parameter int CW = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ep0sr_tmr_if.timer tm
);
  typedef struct packed {
    logic armed;
    logic miss;
    logic [CW-1:0] cnt;
  } ep0sr_tms_t;
  ep0sr_tms_t t_q, t_d;

  assign tm.miss = t_q.miss;

  // restart on each frame; expiry one period after the last frame
  always_comb begin
    t_d = t_q;
    t_d.miss = 1'b0;
    if (tm.clear) begin
      t_d = '0;
    end else if (tm.seen) begin
      t_d.armed = 1'b1;
      t_d.cnt = '0;
    end else if (t_q.armed) begin
      if (t_q.cnt == CW'(PERIOD - 1)) begin
        t_d.miss = 1'b1;
        t_d.cnt = '0;
      end else begin
        t_d.cnt = t_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_q <= '0;
    end else if (ce) begin
      t_q <= t_d;
    end
  end
endmodule

/* File: ep0sr_host.sv */
// Purpose: host model for endpoint-zero traffic
// Assumes: decoded packets, one strobe each
// Notes: idle data lines show inverted values
module ep0sr_host (
  input wire logic clk,
  output logic setup_valid,
  output logic [63:0] setup_bytes,
  output logic sof_valid,
  output logic [10:0] sof_frame,
  output logic tok_valid,
  output logic [6:0] tok_addr,
  output logic status_tok,
  output logic usb_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus from time zero
  initial begin
    {setup_valid, sof_valid, tok_valid, status_tok, usb_reset} = 5'h00;
    setup_bytes = 64'h0;
    sof_frame = 11'h000;
    tok_addr = 7'h00;
  end
  // stale bytes inverted to expose late samples
  task automatic setup(input logic [63:0] b);
    @(posedge clk);
    setup_valid <= 1'b1;
    setup_bytes <= b;
    @(posedge clk);
    setup_valid <= 1'b0;
    setup_bytes <= ~b;
  endtask
  // start of frame, 11-bit number
  task automatic sof(input logic [10:0] f);
    @(posedge clk);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge clk);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
  endtask
  task automatic tok(input logic [6:0] a);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_addr <= a;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
  endtask
  task automatic status();
    @(posedge clk);
    status_tok <= 1'b1;
    @(posedge clk);
    status_tok <= 1'b0;
  endtask
  task automatic bus_reset();
    @(posedge clk);
    usb_reset <= 1'b1;
    @(posedge clk);
    usb_reset <= 1'b0;
  endtask
endmodule

/* File: ep0sr_checker.sv */
// Purpose: port assertions for the handler
// Assumes: ce high
// Notes: bound to the core below
module ep0sr_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tok_valid,
  input wire logic [6:0] tok_addr,
  input wire logic status_tok,
  input wire logic usb_reset,
  input wire logic detach,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  input wire logic [6:0] function_address,
  input wire logic addr_match,
  input wire logic status_ack,
  input wire logic status_nak,
  input wire logic sof_event,
  input wire logic [10:0] frame_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // own tokens match next cycle; a bus reset clears the match
  property p_match;
    ce && tok_valid && tok_addr == function_address && !usb_reset
      && !detach |=> addr_match;
  endproperty
  a_match: assert property (p_match)
    else $error("own token not matched");
  property p_nomatch;
    ce && tok_valid && tok_addr != function_address && !usb_reset
      && !detach |=> !addr_match;
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("foreign token matched");
  property p_status;
    ce && status_tok |=> status_ack != status_nak;
  endproperty
  a_status: assert property (p_status)
    else $error("status not answered once");
  // address moves only on ack or to zero
  property p_addr_hold;
    $changed(function_address) |-> status_ack || function_address == 7'h00;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed");
  property p_addr_clr;
    ce && (usb_reset || detach) |=> function_address == 7'h00;
  endproperty
  a_addr_clr: assert property (p_addr_clr)
    else $error("address not cleared");
  property p_sof;
    ce && sof_valid && !usb_reset && !detach
      |=> sof_event && frame_count == $past(sof_frame);
  endproperty
  a_sof: assert property (p_sof)
    else $error("frame not from packet");
  // synthetic frames step by one, 11-bit wrap
  property p_synth;
    sof_event && !$past(sof_valid)
      |-> frame_count == $past(frame_count) + 11'h001;
  endproperty
  a_synth: assert property (p_synth)
    else $error("synthetic frame wrong");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
endmodule

bind ep0sr_core ep0sr_checker chk_i (.*);

/* File: tb.sv */
// Purpose: bench for the request handler
// Assumes: 50-cycle frames
// Notes: answers checked from queues
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, in_done, detach;
  logic [7:0] s_axi_awaddr, s_axi_araddr, control_in_byte_count;
  logic [7:0] sync_endpoint_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, control_in_buffer;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, setup_valid, sof_valid, tok_valid;
  logic status_tok, usb_reset, addr_match, status_ack, status_nak;
  logic in_armed, sof_event, ep_toggle_rst, ep_busy_clr, ep_out_rearm;
  logic sync_valid;
  logic [63:0] setup_bytes;
  logic [10:0] sof_frame, frame_count;
  logic [6:0] tok_addr, function_address, adr;
  logic [15:0] ep_mask;
  logic [7:0] cfg, alt, ifn, c;
  logic [33:0] rq[$], bq[$], sq[$];
  integer seed, r;
  int n_fail, num_checks;
  ep0sr_core #(.SOF_CYCLES(50)) DUT (.*);
  ep0sr_host host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [33:0] ok(logic [31:0] d);
    return {ep0sr_pkg::RESP_OKAY, d};
  endfunction
  // setup packet: type, request, byte 2, byte 4
  function automatic logic [63:0] pk(logic [7:0] t, logic [7:0] q,
                                     logic [7:0] v, logic [7:0] i);
    return {24'h0, i, 8'h00, v, q, t};
  endfunction
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    finish_test();
  endtask
  // one word write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bq.push_back(ok(32'h0));
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 99) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 99) hang();
  endtask
  task automatic st(input logic ack);
    sq.push_back({32'h0, ack, ~ack});
    host.status();
  endtask
  // answers checked in order
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, bq.pop_front());
    if (status_ack || status_nak)
      chk({32'h0, status_ack, status_nak}, sq.pop_front());
  end
  initial begin
    #200000;
    hang();
  end
  initial begin
    {rst, ce, in_done, detach} = 4'hC;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    num_checks = 0;
    seed = 32'h67FD;
    r = $random(seed);
    cfg = r[7:0];
    alt = r[15:8];
    ifn = {6'h00, r[17:16]};
    adr = r[30:24] | 7'h01;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.tok(7'h00);
    rd(ep0sr_pkg::OFS_FN_ADDR, ok(32'h0));
    rd(8'h30, {ep0sr_pkg::RESP_SLVERR, 32'h0});
    host.setup(pk(8'h00, 8'h09, cfg, 8'h00));
    rd(ep0sr_pkg::OFS_SETUP_LO, ok({8'h00, cfg, 16'h0900}));
    rd(ep0sr_pkg::OFS_CTRL, ok(32'h1));
    st(1'b0);
    wr(ep0sr_pkg::OFS_CONFIG, {24'h0, cfg});
    wr(ep0sr_pkg::OFS_CTRL, 32'h1);
    rd(ep0sr_pkg::OFS_CTRL, ok(32'h0));
    st(1'b1);
    // config via IN buffer
    host.setup(pk(8'h80, 8'h08, 8'h00, 8'h00));
    rd(ep0sr_pkg::OFS_CONFIG, ok({24'h0, cfg}));
    wr(ep0sr_pkg::OFS_IN_BUF, {24'h0, cfg});
    wr(ep0sr_pkg::OFS_IN_BC, 32'h1);
    rd(ep0sr_pkg::OFS_CTRL, ok(32'h3));
    chk({26'h0, control_in_byte_count}, 34'h1);
    chk(ok(control_in_buffer), ok({24'h0, cfg}));
    wr(ep0sr_pkg::OFS_CTRL, 32'h1);
    st(1'b1);
    in_done <= 1'b1;
    @(posedge clk) in_done <= 1'b0;
    rd(ep0sr_pkg::OFS_CTRL, ok(32'h0));
    // alt setting, endpoints re-armed
    host.setup(pk(8'h00, 8'h0B, alt, ifn));
    wr(ep0sr_pkg::OFS_ALT, {16'h0, ifn, alt});
    wr(ep0sr_pkg::OFS_EP_CMD, 32'h000700F0);
    chk(ok({16'h0, ep_mask}), ok(32'h00F0));
    wr(ep0sr_pkg::OFS_CTRL, 32'h1);
    st(1'b1);
    host.setup(pk(8'h81, 8'h0A, 8'h00, ifn));
    rd(ep0sr_pkg::OFS_ALT, ok({24'h0, alt}));
    wr(ep0sr_pkg::OFS_CTRL, 32'h1);
    st(1'b1);
    // core takes the address; writes ignored
    host.setup(pk(8'h00, 8'h05, {1'b0, adr}, 8'h00));
    st(1'b1);
    wr(ep0sr_pkg::OFS_FN_ADDR, {25'h0, ~adr});
    rd(ep0sr_pkg::OFS_FN_ADDR, ok({25'h0, adr}));
    host.tok(adr);
    host.tok(7'h00);
    host.bus_reset();
    rd(ep0sr_pkg::OFS_FN_ADDR, ok(32'h0));
    // iso codes only
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 8'h08 : (k == 1) ? 8'h8F : 8'h40;
      host.setup(pk(8'h82, 8'h0C, 8'h00, c));
      rd(ep0sr_pkg::OFS_SYNC, ok({23'h0, k < 2, c}));
    end
    // wrap on a missed frame
    host.sof(11'h7FF);
    rd(ep0sr_pkg::OFS_FRAME_LO, ok(32'hFF));
    rd(ep0sr_pkg::OFS_FRAME_HI, ok(32'h7));
    repeat (60) @(posedge clk);
    rd(ep0sr_pkg::OFS_FRAME_LO, ok(32'h0));
    rd(ep0sr_pkg::OFS_FRAME_HI, ok(32'h0));
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
